//--- oa_core.sv
// Operand-addressing core with APB control and status
//
// Functional notes
// - 8-bit index register, reset zero, indexes
// - 8-bit stack pointer, reset zero
// - 16-bit program counter, reset zero
// - Core registers never mapped to register space
// - Immediate: operand is source; A/F/SP/X result
// - Direct: memory source, A/X result and source
// - Indexed: operand plus X addresses source
// - Dest direct: write memory, A/X source
// - Dest indexed: operand plus X, A source
// - Dest direct-immediate: address then immediate byte
// - Three-byte direct-immediate, one-byte NOP and modes above direct-immediate, others two bytes
// - Arithmetic combines two sources per mode
// - Flags reset zero-set; bit layout fixed
// - Register space bank from bank-select flag
// - 8-bit accumulator, reset zero, source results
`timescale 1ns/1ns
module oa_core (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Program memory
  output logic [15:0] pm_addr,
  output logic pm_rd,
  input wire logic [7:0] pm_rdata,
  // Data RAM
  output logic [7:0] ram_addr,
  output logic ram_rd,
  output logic ram_wr,
  output logic [7:0] ram_wdata,
  input wire logic [7:0] ram_rdata,
  // Peripheral register space
  output logic [7:0] io_addr,
  output logic io_bank,
  output logic io_rd,
  output logic io_wr,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  // Core status pins
  input wire logic supervisor,
  output logic global_interrupt_enable
);

  oa_pkg::oa_state_t state_q;
  logic [7:0] acc_q;
  logic [7:0] index_q;
  logic [7:0] stack_pointer_reg;
  logic [15:0] program_counter_reg;
  logic [7:0] flags_q;
  logic [7:0] opc_q;
  logic [7:0] op1_q;
  logic [7:0] op2_q;
  logic [7:0] mem_q;
  logic [1:0] cnt_q;
  logic run_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [15:0] pm_addr_q;
  logic pm_rd_q;
  logic [7:0] d_addr_q;
  logic d_rd_q;
  logic d_wr_q;
  logic d_space_q;
  logic [7:0] d_wdata_q;

  // Opcode decode
  logic [2:0] op;
  logic [2:0] mode;
  logic space;
  logic tgt_x;
  logic [1:0] len;
  logic [1:0] len_new;
  logic dst_mode;
  logic need_rd;
  logic [7:0] eff_addr;
  logic [7:0] tgt_val;
  logic [7:0] src;
  logic [7:0] other;
  logic [8:0] sum;
  logic [7:0] res;
  logic carry_n;
  logic flag_upd;

  assign op = opc_q[oa_pkg::OP_HI:oa_pkg::OP_LO];
  assign mode = opc_q[oa_pkg::MD_HI:oa_pkg::MD_LO];
  assign space = opc_q[oa_pkg::SPC_BIT];
  assign tgt_x = opc_q[oa_pkg::TGT_BIT];

  always_comb begin
    len = oa_pkg::LEN2;
    if (op == oa_pkg::OP_NOP || mode > oa_pkg::MD_DDIMM) begin
      len = oa_pkg::LEN1;
    end else if (mode == oa_pkg::MD_DDIMM) begin
      len = oa_pkg::LEN3;
    end
  end

  // Length of the byte now arriving as an opcode: one byte, else two (direct-immediate also reads as two)
  always_comb begin
    len_new = oa_pkg::LEN2;
    if (pm_rdata[oa_pkg::OP_HI:oa_pkg::OP_LO] == oa_pkg::OP_NOP ||
        pm_rdata[oa_pkg::MD_HI:oa_pkg::MD_LO] > oa_pkg::MD_DDIMM) begin
      len_new = oa_pkg::LEN1;
    end
  end

  assign dst_mode = (mode == oa_pkg::MD_DDIR) ||
                    (mode == oa_pkg::MD_DIDX) ||
                    (mode == oa_pkg::MD_DDIMM);

  always_comb begin
    need_rd = 1'b0;
    if (len != oa_pkg::LEN1) begin
      if (mode == oa_pkg::MD_DIR || mode == oa_pkg::MD_IDX) begin
        need_rd = 1'b1;
      end else if (dst_mode && op != oa_pkg::OP_MOV) begin
        need_rd = 1'b1;
      end
    end
  end

  always_comb begin
    eff_addr = op1_q;
    if (mode == oa_pkg::MD_IDX || mode == oa_pkg::MD_DIDX) begin
      eff_addr = 8'(op1_q + index_q);
    end
  end

  assign tgt_val = tgt_x ? index_q : acc_q;

  // Source and second source selection
  always_comb begin
    src = op1_q;
    other = tgt_val;
    case (mode)
      oa_pkg::MD_IMM: begin
        src = op1_q;
        case ({space, tgt_x})
          oa_pkg::TG_A: other = acc_q;
          oa_pkg::TG_X: other = index_q;
          oa_pkg::TG_F: other = flags_q;
          oa_pkg::TG_SP: other = stack_pointer_reg;
          default: other = acc_q;
        endcase
      end
      oa_pkg::MD_DIR, oa_pkg::MD_IDX: begin
        src = mem_q;
        other = tgt_val;
      end
      oa_pkg::MD_DDIR: begin
        src = tgt_val;
        other = mem_q;
      end
      oa_pkg::MD_DIDX: begin
        src = acc_q;
        other = mem_q;
      end
      oa_pkg::MD_DDIMM: begin
        src = op2_q;
        other = mem_q;
      end
      default: begin
        src = op1_q;
        other = tgt_val;
      end
    endcase
  end

  // Two-source arithmetic and logic
  always_comb begin
    sum = 9'h000;
    res = src;
    carry_n = flags_q[oa_pkg::F_CARRY];
    flag_upd = 1'b1;
    case (op)
      oa_pkg::OP_MOV: begin
        res = src;
        flag_upd = 1'b0;
      end
      oa_pkg::OP_ADD: begin
        sum = {1'b0, other} + {1'b0, src};
        res = sum[7:0];
        carry_n = sum[8];
      end
      oa_pkg::OP_ADC: begin
        sum = {1'b0, other} + {1'b0, src} +
              {8'h00, flags_q[oa_pkg::F_CARRY]};
        res = sum[7:0];
        carry_n = sum[8];
      end
      oa_pkg::OP_SUB: begin
        sum = {1'b0, other} - {1'b0, src};
        res = sum[7:0];
        carry_n = sum[8];
      end
      oa_pkg::OP_AND: res = other & src;
      oa_pkg::OP_OR: res = other | src;
      oa_pkg::OP_XOR: res = other ^ src;
      default: begin
        res = other;
        flag_upd = 1'b0;
      end
    endcase
  end

  // Instruction sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= oa_pkg::S_IDLE;
      cnt_q <= 2'h0;
    end else begin
      case (state_q)
        oa_pkg::S_IDLE: begin
          if (run_q) begin
            state_q <= oa_pkg::S_FETCH;
          end
        end
        oa_pkg::S_FETCH: state_q <= oa_pkg::S_FWAIT;
        oa_pkg::S_FWAIT: state_q <= oa_pkg::S_FCAP;
        oa_pkg::S_FCAP: begin
          cnt_q <= 2'(cnt_q + 2'h1);
          if (cnt_q == 2'h0) begin
            if (len_new == oa_pkg::LEN1) begin
              state_q <= oa_pkg::S_EXEC;
            end else begin
              state_q <= oa_pkg::S_FETCH;
            end
          end else if (2'(cnt_q + 2'h1) < len) begin
            state_q <= oa_pkg::S_FETCH;
          end else if (need_rd) begin
            state_q <= oa_pkg::S_DREQ;
          end else begin
            state_q <= oa_pkg::S_EXEC;
          end
        end
        oa_pkg::S_DREQ: state_q <= oa_pkg::S_DWAIT;
        oa_pkg::S_DWAIT: state_q <= oa_pkg::S_DCAP;
        oa_pkg::S_DCAP: state_q <= oa_pkg::S_EXEC;
        oa_pkg::S_EXEC: begin
          cnt_q <= 2'h0;
          state_q <= run_q ? oa_pkg::S_FETCH : oa_pkg::S_IDLE;
        end
        default: state_q <= oa_pkg::S_IDLE;
      endcase
    end
  end

  // Opcode and operand capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opc_q <= 8'h00;
      op1_q <= 8'h00;
      op2_q <= 8'h00;
    end else if (state_q == oa_pkg::S_FCAP) begin
      case (cnt_q)
        2'h0: opc_q <= pm_rdata;
        2'h1: op1_q <= pm_rdata;
        default: op2_q <= pm_rdata;
      endcase
    end
  end

  // Program counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      program_counter_reg <= oa_pkg::PC_RST;
    end else if (state_q == oa_pkg::S_FCAP) begin
      program_counter_reg <= 16'(program_counter_reg + 16'h0001);
    end
  end

  // Program memory strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm_addr_q <= oa_pkg::PC_RST;
      pm_rd_q <= 1'b0;
    end else begin
      pm_rd_q <= (state_q == oa_pkg::S_FETCH);
      if (state_q == oa_pkg::S_FETCH) begin
        pm_addr_q <= program_counter_reg;
      end
    end
  end

  // Data access strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d_addr_q <= 8'h00;
      d_rd_q <= 1'b0;
      d_wr_q <= 1'b0;
      d_space_q <= 1'b0;
      d_wdata_q <= 8'h00;
    end else begin
      d_rd_q <= (state_q == oa_pkg::S_DREQ);
      d_wr_q <= (state_q == oa_pkg::S_EXEC) && dst_mode &&
                (len != oa_pkg::LEN1);
      if (state_q == oa_pkg::S_DREQ || state_q == oa_pkg::S_EXEC) begin
        d_addr_q <= eff_addr;
        d_space_q <= space;
        d_wdata_q <= res;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_q <= 8'h00;
    end else if (state_q == oa_pkg::S_DCAP) begin
      mem_q <= d_space_q ? io_rdata : ram_rdata;
    end
  end

  // Core registers, reachable only by execution
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= oa_pkg::A_RST;
      index_q <= oa_pkg::X_RST;
      stack_pointer_reg <= oa_pkg::SP_RST;
    end else if (state_q == oa_pkg::S_EXEC && len != oa_pkg::LEN1) begin
      if (mode == oa_pkg::MD_IMM) begin
        case ({space, tgt_x})
          oa_pkg::TG_A: acc_q <= res;
          oa_pkg::TG_X: index_q <= res;
          oa_pkg::TG_SP: stack_pointer_reg <= res;
          default: ;
        endcase
      end else if (!dst_mode) begin
        if (tgt_x) begin
          index_q <= res;
        end else begin
          acc_q <= res;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= oa_pkg::F_RST;
    end else begin
      flags_q[oa_pkg::F_SUPER] <= supervisor;
      if (state_q == oa_pkg::S_EXEC && len != oa_pkg::LEN1) begin
        if (mode == oa_pkg::MD_IMM && {space, tgt_x} == oa_pkg::TG_F) begin
          flags_q[oa_pkg::F_GIE] <= res[oa_pkg::F_GIE];
          flags_q[oa_pkg::F_ZERO] <= res[oa_pkg::F_ZERO];
          flags_q[oa_pkg::F_CARRY] <= res[oa_pkg::F_CARRY];
          flags_q[oa_pkg::F_BANK] <= res[oa_pkg::F_BANK];
        end else if (flag_upd) begin
          flags_q[oa_pkg::F_ZERO] <= (res == 8'h00);
          flags_q[oa_pkg::F_CARRY] <= carry_n;
        end
      end
    end
  end

  assign global_interrupt_enable = flags_q[oa_pkg::F_GIE];

  // Memory ports
  assign pm_addr = pm_addr_q;
  assign pm_rd = pm_rd_q;
  assign ram_addr = d_addr_q;
  assign ram_rd = d_rd_q && !d_space_q;
  assign ram_wr = d_wr_q && !d_space_q;
  assign ram_wdata = d_wdata_q;
  assign io_addr = d_addr_q;
  assign io_bank = flags_q[oa_pkg::F_BANK];
  assign io_rd = d_rd_q && d_space_q;
  assign io_wr = d_wr_q && d_space_q;
  assign io_wdata = d_wdata_q;

  // APB slave: run control and status only
  logic ctrl_hit;
  logic stat_hit;
  assign ctrl_hit = (paddr == oa_pkg::CTRL_OFS);
  assign stat_hit = (paddr == oa_pkg::STAT_OFS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= oa_pkg::CTRL_RST;
    end else if (psel && penable && pwrite && ctrl_hit) begin
      run_q <= pwdata[oa_pkg::CTRL_RUN];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (psel && !penable) begin
      pslverr_q <= !(ctrl_hit || stat_hit);
      prdata_q <= 32'h0000_0000;
      if (ctrl_hit && !pwrite) begin
        prdata_q[oa_pkg::CTRL_RUN] <= run_q;
      end else if (stat_hit && !pwrite) begin
        prdata_q[15:0] <= program_counter_reg;
        prdata_q[oa_pkg::STAT_BUSY] <= (state_q != oa_pkg::S_IDLE);
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = pslverr_q && psel && penable;

endmodule // oa_core

//--- oa_pkg.sv
// Package with constants and types for the operand-addressing core
package oa_pkg;
  localparam int DW = 8;
  localparam int PCW = 16;
  localparam int AW = 32;
  // Core register reset values
  localparam logic [7:0] A_RST = 8'h00;
  localparam logic [7:0] X_RST = 8'h00;
  localparam logic [7:0] SP_RST = 8'h00;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] F_RST = 8'h02;
  // Flag bit positions
  localparam int F_GIE = 0;
  localparam int F_ZERO = 1;
  localparam int F_CARRY = 2;
  localparam int F_SUPER = 3;
  localparam int F_BANK = 4;
  localparam logic [7:0] F_WR_MASK = 8'h17;
  // Opcode byte fields
  localparam int OP_HI = 7;
  localparam int OP_LO = 5;
  localparam int MD_HI = 4;
  localparam int MD_LO = 2;
  localparam int SPC_BIT = 1;
  localparam int TGT_BIT = 0;
  // Operations
  localparam logic [2:0] OP_MOV = 3'h0;
  localparam logic [2:0] OP_ADD = 3'h1;
  localparam logic [2:0] OP_ADC = 3'h2;
  localparam logic [2:0] OP_AND = 3'h3;
  localparam logic [2:0] OP_OR = 3'h4;
  localparam logic [2:0] OP_XOR = 3'h5;
  localparam logic [2:0] OP_SUB = 3'h6;
  localparam logic [2:0] OP_NOP = 3'h7;
  // Addressing modes
  localparam logic [2:0] MD_IMM = 3'h0;
  localparam logic [2:0] MD_DIR = 3'h1;
  localparam logic [2:0] MD_IDX = 3'h2;
  localparam logic [2:0] MD_DDIR = 3'h3;
  localparam logic [2:0] MD_DIDX = 3'h4;
  localparam logic [2:0] MD_DDIMM = 3'h5;
  // Immediate-mode targets {space,target}
  localparam logic [1:0] TG_A = 2'h0;
  localparam logic [1:0] TG_X = 2'h1;
  localparam logic [1:0] TG_F = 2'h2;
  localparam logic [1:0] TG_SP = 2'h3;
  // Instruction lengths in bytes
  localparam logic [1:0] LEN1 = 2'h1;
  localparam logic [1:0] LEN2 = 2'h2;
  localparam logic [1:0] LEN3 = 2'h3;
  // APB register map
  localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] STAT_OFS = 32'h0000_0004;
  localparam int CTRL_RUN = 0;
  localparam int STAT_BUSY = 16;
  localparam logic CTRL_RST = 1'b0;
  // Sequencer states
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_FETCH = 3'b001,
    S_FWAIT = 3'b010,
    S_FCAP = 3'b011,
    S_DREQ = 3'b100,
    S_DWAIT = 3'b101,
    S_DCAP = 3'b110,
    S_EXEC = 3'b111
  } oa_state_t;
endpackage

//--- oa_core_chk.sv
// Checker of bus and strobe behaviour at the core's ports
`timescale 1ns/1ns
module oa_core_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Memory side
  input wire logic [15:0] pm_addr,
  input wire logic pm_rd,
  input wire logic ram_rd,
  input wire logic ram_wr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic io_bank,
  input wire logic global_interrupt_enable
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc = psel && penable;
  wire logic unmap = paddr != oa_pkg::CTRL_OFS && paddr != oa_pkg::STAT_OFS;
  sequence two_fetch;
    pm_rd ##3 pm_rd;
  endsequence
  sequence one_pulse(s);
    s ##1 !s;
  endsequence
  reset_vals_a: assert property (
    $rose(presetn) |-> !global_interrupt_enable && !io_bank && !pm_rd)
    else $error("state after reset wrong");
  bad_addr_a: assert property (
    acc && unmap |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  good_addr_a: assert property (
    acc && !unmap |-> !pslverr) else $error("mapped access refused");
  stat_read_a: assert property (
    acc && !pwrite && paddr == oa_pkg::STAT_OFS |-> prdata[31:17] == 15'h0)
    else $error("status upper bits set");
  pc_step_a: assert property (
    two_fetch |-> pm_addr == $past(pm_addr, 3) + 16'h1)
    else $error("fetch address not sequential");
  fetch_pulse_a: assert property (
    pm_rd |-> one_pulse(pm_rd) and !ram_rd && !io_rd)
    else $error("fetch strobe wrong");
  space_excl_a: assert property (
    ram_rd || ram_wr |-> !io_rd && !io_wr) else $error("both spaces hit");
  wr_pulse_a: assert property (
    ram_wr || io_wr |=> !ram_wr && !io_wr) else $error("write too long");
endmodule // oa_core_chk

bind oa_core oa_core_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pslverr, .pm_addr, .pm_rd, .ram_rd, .ram_wr, .io_rd,
  .io_wr, .io_bank, .global_interrupt_enable);

//--- oa_mem_model.sv
// Program memory, data RAM and banked register space model
`timescale 1ns/1ns
module oa_mem_model (
  // Clock
  input wire logic pclk,
  // Program memory
  input wire logic [15:0] pm_addr,
  input wire logic pm_rd,
  output logic [7:0] pm_rdata,
  // Data RAM
  input wire logic [7:0] ram_addr,
  input wire logic ram_rd,
  input wire logic ram_wr,
  input wire logic [7:0] ram_wdata,
  output logic [7:0] ram_rdata,
  // Register space
  input wire logic [7:0] io_addr,
  input wire logic io_bank,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata
);
  logic [7:0] pm [256];
  logic [7:0] ram [256];
  logic [7:0] io [2][256];
  // Data valid one cycle after a strobe, toggling otherwise
  always @(posedge pclk) begin
    pm_rdata <= pm_rd ? pm[pm_addr[7:0]] : ~pm_rdata;
    ram_rdata <= ram_rd ? ram[ram_addr] : ~ram_rdata;
    io_rdata <= io_rd ? io[io_bank][io_addr] : ~io_rdata;
    if (ram_wr) ram[ram_addr] <= ram_wdata;
    if (io_wr) io[io_bank][io_addr] <= io_wdata;
  end
endmodule // oa_mem_model

//--- tb_cpu_operand_addressing.sv
// Self-checking bench for the operand-addressing core
`timescale 1ns/1ns
module tb_cpu_operand_addressing;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [15:0] pm_addr;
  logic [7:0] pm_rdata, ram_addr, ram_wdata, ram_rdata;
  logic [7:0] io_addr, io_wdata, io_rdata;
  logic pm_rd, ram_rd, ram_wr, io_rd, io_wr, io_bank, supervisor, gie;
  logic [7:0] prog[$];
  int error_cnt, num_checks, x, a, m20, m21, ix3;
  int r[4];
  oa_core dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pm_addr, .pm_rd, .pm_rdata,
    .ram_addr, .ram_rd, .ram_wr, .ram_wdata, .ram_rdata, .io_addr,
    .io_bank, .io_rd, .io_wr, .io_wdata, .io_rdata, .supervisor,
    .global_interrupt_enable(gie));
  oa_mem_model mem_u (.pclk, .pm_addr, .pm_rd, .pm_rdata, .ram_addr,
    .ram_rd, .ram_wr, .ram_wdata, .ram_rdata, .io_addr, .io_bank,
    .io_rd, .io_wr, .io_wdata, .io_rdata);
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] ad,
      input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, oa_pkg::STAT_OFS, 32'h0);
    check(rd, 32'h0);
    check({gie, io_bank}, 32'h0);
  endtask
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #2000000;
    error_cnt++;
    stop_test();
  end
  initial begin
    {psel, penable, pwrite, supervisor, presetn} = 5'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    error_cnt = 0;
    num_checks = 0;
    void'($urandom(32'h0d24));
    supervisor <= 1'($urandom);
    for (int i = 0; i < 256; i++) begin
      mem_u.ram[i] = 8'($urandom);
      mem_u.io[0][i] = 8'($urandom);
      mem_u.io[1][i] = 8'($urandom);
      mem_u.pm[i] = 8'he0;
    end
    foreach (r[i]) r[i] = $urandom % 256;
    x = 64 + r[0] % 8;
    prog = '{8'h01, 8'(x), 8'h00, 8'(r[1]), 8'h24, 8'h10, 8'hc8, 8'h02,
      8'h2c, 8'h20, 8'hb2, 8'h03, 8'h02, 8'h11, 8'h16, 8'h30, 8'(r[2]),
      8'h34, 8'h21, 8'(r[3])};
    foreach (prog[i]) mem_u.pm[i] = prog[i];
    a = (r[1] + mem_u.ram[16]) % 256;
    a = (a - mem_u.ram[x + 2]) & 255;
    m20 = (mem_u.ram[32] + a) % 256;
    ix3 = mem_u.io[0][x + 3] ^ a;
    m21 = (mem_u.ram[33] + r[3]) % 256;
    do_reset();
    for (int i = 2; i < 8; i++) begin
      apb(i % 2, 32'(i * 4), 32'hff);
      check(er, 1'b1);
      check(rd, 32'h0);
    end
    apb(1, oa_pkg::CTRL_OFS, 32'h0);
    apb(0, oa_pkg::CTRL_OFS, 32'h0);
    check(rd, 32'h0);
    check(er, 1'b0);
    $display("test map done");
    apb(1, oa_pkg::CTRL_OFS, 32'h1);
    do apb(0, oa_pkg::STAT_OFS, 32'h0); while (rd[15:0] < 16'd20);
    apb(1, oa_pkg::CTRL_OFS, 32'h0);
    do apb(0, oa_pkg::STAT_OFS, 32'h0); while (rd[16] !== 1'b0);
    check(mem_u.ram[32], m20);
    check(mem_u.io[0][x + 3], ix3);
    check(mem_u.io[1][48], r[2]);
    check(mem_u.ram[33], m21);
    check({gie, io_bank}, 32'h3);
    check(dut_u.flags_q[oa_pkg::F_SUPER], supervisor);
    $display("test modes done");
    apb(1, oa_pkg::CTRL_OFS, 32'h1);
    repeat (7) @(posedge pclk);
    do_reset();
    $display("test reset done");
    stop_test();
  end
endmodule // tb_cpu_operand_addressing
